// File: pkg/lamp_pkg.sv
/*
  Constants for the indicator lamp driver: register indices, field positions,
  reset values, function codes and timing counts.
  Assumes a 100 MHz core clock and a register port inside the transceiver.
*/
package lamp_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_CONTROL_FIRST = 16'h001B;
  localparam logic [15:0] ADDR_FUNCTION_LOW  = 16'h001C;
  localparam logic [15:0] ADDR_BLINK_PATTERN = 16'h001D;
  localparam logic [15:0] ADDR_STRETCH_CUSTOM = 16'hBC00;

  localparam logic [15:0] RST_FUNCTION_LOW   = 16'h210A;
  localparam logic [15:0] RST_BLINK_PATTERN  = 16'h1855;
  localparam logic [15:0] RST_CONTROL_FIRST  = 16'h0001;
  localparam logic [5:0]  RST_STRETCH_CUSTOM = 6'h00;

  // Fields of the first control register
  localparam int TOP_BIT_POS     = 10;
  localparam int PAUSE_LSB       = 4;
  localparam int STRETCH_SEL_LSB = 2;
  localparam int DISABLE_POS     = 1;
  localparam int STRETCH_EN_POS  = 0;
  localparam logic [15:0] CONTROL_FIRST_MASK = 16'h04FF;

  // Fields of the blink pattern register
  localparam int TICK_LSB = 8;
  localparam logic [5:0] TICK_ONE_MS = 6'h3F;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int MS_TIME       = 1;
  localparam int MS_CYCLES     = MS_TIME * CLK_MHZ * 1000;
  localparam int TICK_UNIT_MS  = 8;
  localparam int STRETCH0_MS   = 32;
  localparam int STRETCH1_MS   = 64;
  localparam int STRETCH2_MS   = 102;

  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [4:0] F_ON10_BLINK100 = 5'h1F;
  localparam logic [4:0] F_ON100_BLINK10 = 5'h1D;
  localparam logic [4:0] F_ON100         = 5'h1C;
  localparam logic [4:0] F_BLINK10       = 5'h1B;
  localparam logic [4:0] F_BLINK_TX      = 5'h1A;
  localparam logic [4:0] F_BLINK_ACT     = 5'h19;
  localparam logic [4:0] F_ON100_ACT     = 5'h13;
  localparam logic [4:0] F_ON10_ACT      = 5'h12;
  localparam logic [4:0] F_ON_ANY_LINK   = 5'h10;
  localparam logic [4:0] F_OFF           = 5'h0F;
  localparam logic [4:0] F_ON            = 5'h0E;
  localparam logic [4:0] F_BLINK         = 5'h0D;
  localparam logic [4:0] F_FDX_COL       = 5'h0C;
  localparam logic [4:0] F_LINK_RX       = 5'h0B;
  localparam logic [4:0] F_LINK_ACT      = 5'h0A;
  localparam logic [4:0] F_COL           = 5'h09;
  localparam logic [4:0] F_FDX           = 5'h08;
  localparam logic [4:0] F_ACT           = 5'h07;
  localparam logic [4:0] F_RX            = 5'h06;
  localparam logic [4:0] F_TX            = 5'h05;
  localparam logic [4:0] F_LINK          = 5'h04;
  localparam logic [4:0] F_BLINK100      = 5'h03;
endpackage

// File: logic/pulse_stretcher.sv
/*
  Holds a short event indication high for a selectable number of
  milliseconds. Assumes the event input is already in the core clock domain
  and a one-cycle millisecond strobe from the parent.
*/
`timescale 1ns/1ps
module pulse_stretcher (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       event_in,
  input  wire logic       ms_tick_in,
  input  wire logic       enable_in,
  input  wire logic [1:0] length_sel_in,
  input  wire logic [5:0] custom_ms_in,
  output logic            stretched_out
);
  typedef struct packed {
    logic [6:0] left;
    logic       hold;
  } stretch_state_t;

  stretch_state_t s_r;
  stretch_state_t s_nxt;
  logic [6:0]     length_ms;

  always_comb begin
    case (length_sel_in)
      2'h0:    length_ms = 7'(lamp_pkg::STRETCH0_MS);
      2'h1:    length_ms = 7'(lamp_pkg::STRETCH1_MS);
      2'h2:    length_ms = 7'(lamp_pkg::STRETCH2_MS);
      default: length_ms = {1'b0, custom_ms_in};
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // A fresh event restarts the window
    if (event_in) begin
      s_nxt.left = length_ms;
      s_nxt.hold = 1'b1;
    end else if (ms_tick_in && s_r.left != 7'h00) begin
      s_nxt.left = s_r.left - 7'h01;
    end else if (s_r.left == 7'h00) begin
      s_nxt.hold = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pass-through when disabled; stretched output follows event immediately
  assign stretched_out = enable_in ? (event_in | s_r.hold) : event_in;
endmodule // pulse_stretcher

// File: logic/lamp_driver.sv
/*
  Indicator lamp driver: function select, blink pattern generator, pulse
  stretching and the lamp control registers.
  Assumes status inputs come from the core on the same clock and a simple
  internal register port with one-cycle read/write strobes.
*/
`timescale 1ns/1ps
// Behaviour
// - Function code is top bit plus four
// - Reset code 01010: link on, activity blink
// - 11111 on10 blink100; 11101 reversed
// - 11100 on at 100; 11011 blink at 10
// - 11010 blink transmit; 11001 blink activity
// - 10011/10010 speed link on, activity blink
// - 10000 on with any link
// - 01111 off, 01110 on, 01101 blink
// - 01100 full duplex on, collision blink
// - 01011 link on, receive blink
// - 01000 full duplex; 01001 collision
// - 00111 activity, 00110 receive, 00101 transmit
// - 00100 link up; 00011 blink at 100
// - Bank select reads zero always
// - Tick is (value plus one) times 8 ms
// - Tick value 63 means 1 ms
// - Pattern bits shift out one per tick
// - Pattern resets 0x55, tick 0x18
// - Hold last bit for pause times tick
// - Output disable bit turns lamp off
// - Stretch short transmit, receive, collision events
// - Stretch 32, 64, 102 ms or custom
module lamp_driver (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  output logic             reg_ack_out,
  input  wire logic        link_up_in,
  input  wire logic        speed_100_in,
  input  wire logic        full_duplex_in,
  input  wire logic        tx_active_in,
  input  wire logic        rx_active_in,
  input  wire logic        collision_in,
  output logic             indicator_lamp_pin_out,
  output logic             indicator_lamp_pin_oe_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] control_first;
    logic [3:0]  lamp_func_low_bits;
    logic [11:0] function_spare;
    logic [5:0]  pattern_tick_length;
    logic [7:0]  blink_bit_pattern;
    logic [5:0]  stretch_custom;
    logic [16:0] ms_count;
    logic        ms_tick;
    logic [8:0]  tick_ms_count;
    logic [2:0]  bit_index;
    logic [3:0]  pause_count;
    logic        pausing;
    logic        blink_bit;
    logic        lamp;
    logic        lamp_oe;
    logic [15:0] rdata;
    logic        ack;
  } lamp_state_t;

  lamp_state_t st_r;
  lamp_state_t st_nxt;

  logic       tx_s;
  logic       rx_s;
  logic       col_s;
  logic [4:0] func_code;
  logic [8:0] tick_ms;
  logic       is_link10;
  logic       is_link100;
  logic       act;

  // Tick length in ms from the six-bit field
  function automatic logic [8:0] tick_length_ms(input logic [5:0] v);
    if (v == lamp_pkg::TICK_ONE_MS) begin
      tick_length_ms = 9'(lamp_pkg::MS_TIME);
    end else begin
      tick_length_ms = ({3'h0, v} + 9'h001) * 9'(lamp_pkg::TICK_UNIT_MS);
    end
  endfunction

  // Register select, shared by the write and the read path
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CONTROL_FIRST,
    SEL_FUNCTION_LOW,
    SEL_BLINK_PATTERN,
    SEL_STRETCH_CUSTOM
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [15:0] a);
    if (a == lamp_pkg::ADDR_CONTROL_FIRST) begin
      decode_addr = SEL_CONTROL_FIRST;
    end else if (a == lamp_pkg::ADDR_FUNCTION_LOW) begin
      decode_addr = SEL_FUNCTION_LOW;
    end else if (a == lamp_pkg::ADDR_BLINK_PATTERN) begin
      decode_addr = SEL_BLINK_PATTERN;
    end else if (a == lamp_pkg::ADDR_STRETCH_CUSTOM) begin
      decode_addr = SEL_STRETCH_CUSTOM;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction

  reg_sel_t reg_sel;
  assign reg_sel = decode_addr(reg_addr_in);

  // ---------------------------------------------------------------
  // Event stretching
  // ---------------------------------------------------------------
  logic [1:0] sel;
  logic       str_en;
  assign sel    = st_r.control_first[lamp_pkg::STRETCH_SEL_LSB +: 2];
  assign str_en = st_r.control_first[lamp_pkg::STRETCH_EN_POS];

  pulse_stretcher u_tx (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .event_in      (tx_active_in),
    .ms_tick_in    (st_r.ms_tick),
    .enable_in     (str_en),
    .length_sel_in (sel),
    .custom_ms_in  (st_r.stretch_custom),
    .stretched_out (tx_s)
  );
  pulse_stretcher u_rx (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .event_in      (rx_active_in),
    .ms_tick_in    (st_r.ms_tick),
    .enable_in     (str_en),
    .length_sel_in (sel),
    .custom_ms_in  (st_r.stretch_custom),
    .stretched_out (rx_s)
  );
  pulse_stretcher u_col (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .event_in      (collision_in),
    .ms_tick_in    (st_r.ms_tick),
    .enable_in     (str_en),
    .length_sel_in (sel),
    .custom_ms_in  (st_r.stretch_custom),
    .stretched_out (col_s)
  );

  assign func_code  = {st_r.control_first[lamp_pkg::TOP_BIT_POS],
                       st_r.lamp_func_low_bits};
  assign tick_ms    = tick_length_ms(st_r.pattern_tick_length);
  assign is_link10  = link_up_in & ~speed_100_in;
  assign is_link100 = link_up_in & speed_100_in;
  assign act        = tx_s | rx_s;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic b;
    logic lamp_on;
    b       = st_r.blink_bit;
    lamp_on = 1'b0;
    st_nxt  = st_r;
    st_nxt.ack = 1'b0;

    // Millisecond timebase
    st_nxt.ms_tick = 1'b0;
    if (st_r.ms_count == 17'(lamp_pkg::MS_CYCLES - 1)) begin
      st_nxt.ms_count = '0;
      st_nxt.ms_tick  = 1'b1;
    end else begin
      st_nxt.ms_count = st_r.ms_count + 17'h00001;
    end

    // Pattern generator: one bit per tick, then pause, then repeat
    if (st_r.ms_tick) begin
      if (st_r.tick_ms_count + 9'h001 >= tick_ms) begin
        st_nxt.tick_ms_count = '0;
        if (st_r.pausing) begin
          if (st_r.pause_count <= 4'h1) begin
            st_nxt.pausing   = 1'b0;
            st_nxt.bit_index = '0;
            st_nxt.blink_bit = st_r.blink_bit_pattern[0];
          end else begin
            st_nxt.pause_count = st_r.pause_count - 4'h1;
          end
        end else if (st_r.bit_index == 3'h7) begin
          st_nxt.pause_count = st_r.control_first[lamp_pkg::PAUSE_LSB +: 4];
          if (st_r.control_first[lamp_pkg::PAUSE_LSB +: 4] == 4'h0) begin
            st_nxt.bit_index = '0;
            st_nxt.blink_bit = st_r.blink_bit_pattern[0];
          end else begin
            st_nxt.pausing = 1'b1;
          end
        end else begin
          st_nxt.bit_index = st_r.bit_index + 3'h1;
          st_nxt.blink_bit = st_r.blink_bit_pattern[st_r.bit_index + 3'h1];
        end
      end else begin
        st_nxt.tick_ms_count = st_r.tick_ms_count + 9'h001;
      end
    end

    // Function selection
    case (func_code)
      lamp_pkg::F_ON10_BLINK100: lamp_on = is_link10 | (is_link100 & b);
      lamp_pkg::F_ON100_BLINK10: lamp_on = is_link100 | (is_link10 & b);
      lamp_pkg::F_ON100:         lamp_on = is_link100;
      lamp_pkg::F_BLINK10:       lamp_on = is_link10 & b;
      lamp_pkg::F_BLINK_TX:      lamp_on = tx_s & b;
      lamp_pkg::F_BLINK_ACT:     lamp_on = act & b;
      lamp_pkg::F_ON100_ACT:     lamp_on = is_link100 & (act ? b : 1'b1);
      lamp_pkg::F_ON10_ACT:      lamp_on = is_link10 & (act ? b : 1'b1);
      lamp_pkg::F_ON_ANY_LINK:   lamp_on = link_up_in;
      lamp_pkg::F_OFF:           lamp_on = 1'b0;
      lamp_pkg::F_ON:            lamp_on = 1'b1;
      lamp_pkg::F_BLINK:         lamp_on = b;
      lamp_pkg::F_FDX_COL:       lamp_on = col_s ? b : (link_up_in & full_duplex_in);
      lamp_pkg::F_LINK_RX:       lamp_on = link_up_in & (rx_s ? b : 1'b1);
      lamp_pkg::F_LINK_ACT:      lamp_on = link_up_in & (act ? b : 1'b1);
      lamp_pkg::F_COL:           lamp_on = col_s;
      lamp_pkg::F_FDX:           lamp_on = link_up_in & full_duplex_in;
      lamp_pkg::F_ACT:           lamp_on = act;
      lamp_pkg::F_RX:            lamp_on = rx_s;
      lamp_pkg::F_TX:            lamp_on = tx_s;
      lamp_pkg::F_LINK:          lamp_on = link_up_in;
      lamp_pkg::F_BLINK100:      lamp_on = is_link100 & b;
      default:                   lamp_on = 1'b0;
    endcase

    // Disabled lamp is released and driven low
    st_nxt.lamp_oe = ~st_r.control_first[lamp_pkg::DISABLE_POS];
    st_nxt.lamp    = lamp_on & ~st_r.control_first[lamp_pkg::DISABLE_POS];

    // Register port
    if (reg_wr_in) begin
      st_nxt.ack = 1'b1;
      if (reg_sel == SEL_CONTROL_FIRST) begin
        st_nxt.control_first = reg_wdata_in & lamp_pkg::CONTROL_FIRST_MASK;
      end else if (reg_sel == SEL_FUNCTION_LOW) begin
        st_nxt.lamp_func_low_bits = reg_wdata_in[3:0];
        st_nxt.function_spare     = reg_wdata_in[15:4];
      end else if (reg_sel == SEL_BLINK_PATTERN) begin
        // Bank select is not stored; only bank zero exists
        st_nxt.pattern_tick_length = reg_wdata_in[lamp_pkg::TICK_LSB +: 6];
        st_nxt.blink_bit_pattern   = reg_wdata_in[7:0];
        // Restart, so a new pattern never shows a stale bit of the old one
        st_nxt.bit_index     = '0;
        st_nxt.tick_ms_count = '0;
        st_nxt.pausing       = 1'b0;
        st_nxt.blink_bit     = reg_wdata_in[0];
      end else if (reg_sel == SEL_STRETCH_CUSTOM) begin
        st_nxt.stretch_custom = reg_wdata_in[5:0];
      end
    end else if (reg_rd_in) begin
      st_nxt.ack = 1'b1;
      if (reg_sel == SEL_CONTROL_FIRST) begin
        st_nxt.rdata = st_r.control_first;
      end else if (reg_sel == SEL_FUNCTION_LOW) begin
        st_nxt.rdata = {st_r.function_spare, st_r.lamp_func_low_bits};
      end else if (reg_sel == SEL_BLINK_PATTERN) begin
        st_nxt.rdata = {2'b00, st_r.pattern_tick_length, st_r.blink_bit_pattern};
      end else if (reg_sel == SEL_STRETCH_CUSTOM) begin
        st_nxt.rdata = {10'h000, st_r.stretch_custom};
      end else begin
        st_nxt.rdata = 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_r                     <= '0;
      st_r.control_first       <= lamp_pkg::RST_CONTROL_FIRST;
      st_r.lamp_func_low_bits  <= lamp_pkg::RST_FUNCTION_LOW[3:0];
      st_r.function_spare      <= lamp_pkg::RST_FUNCTION_LOW[15:4];
      st_r.pattern_tick_length <= lamp_pkg::RST_BLINK_PATTERN[13:8];
      st_r.blink_bit_pattern   <= lamp_pkg::RST_BLINK_PATTERN[7:0];
      st_r.blink_bit           <= lamp_pkg::RST_BLINK_PATTERN[0];
      st_r.stretch_custom      <= lamp_pkg::RST_STRETCH_CUSTOM;
      st_r.lamp_oe             <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign indicator_lamp_pin_out    = st_r.lamp;
  assign indicator_lamp_pin_oe_out = st_r.lamp_oe;
  assign reg_rdata_out             = st_r.rdata;
  assign reg_ack_out               = st_r.ack;
endmodule // lamp_driver

// File: dv/lamp_driver_monitor.sv
/*
  Port-level checks of the lamp driver, bound into every instance.
  Assumes one clock, synchronous active-high reset and a registered lamp.
*/
`timescale 1ns/1ps
module lamp_driver_monitor (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_ack_out,
  input wire logic        link_up_in,
  input wire logic        speed_100_in,
  input wire logic        full_duplex_in,
  input wire logic        tx_active_in,
  input wire logic        rx_active_in,
  input wire logic        collision_in,
  input wire logic        indicator_lamp_pin_out,
  input wire logic        indicator_lamp_pin_oe_out
);
  // ---------------------------------
  // Shadow of the programmed function
  // ---------------------------------
  logic [4:0] code_r;
  logic       off_r;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      code_r <= 5'h0A;
      off_r  <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == lamp_pkg::ADDR_FUNCTION_LOW) begin
        code_r[3:0] <= reg_wdata_in[3:0];
      end
      if (reg_addr_in == lamp_pkg::ADDR_CONTROL_FIRST) begin
        code_r[4] <= reg_wdata_in[lamp_pkg::TOP_BIT_POS];
        off_r     <= reg_wdata_in[lamp_pkg::DISABLE_POS];
      end
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_ack; (reg_wr_in || reg_rd_in) |=> reg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack after strobe");
  property p_ack_cause; reg_ack_out |-> $past(reg_wr_in || reg_rd_in); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  property p_bank; reg_rd_in && !reg_wr_in && reg_addr_in == lamp_pkg::ADDR_BLINK_PATTERN
    |=> reg_rdata_out[15:14] == 2'h0; endproperty
  a_bank: assert property (p_bank) else $error("bank select reads nonzero");
  property p_unmapped; reg_rd_in && !reg_wr_in && !(reg_addr_in inside
    {16'h001B, 16'h001C, 16'h001D, 16'hBC00}) |=> reg_rdata_out == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_readback; reg_wr_in && reg_addr_in == lamp_pkg::ADDR_FUNCTION_LOW ##1 !reg_wr_in
    ##1 reg_rd_in && !reg_wr_in && reg_addr_in == lamp_pkg::ADDR_FUNCTION_LOW
    |=> reg_rdata_out == $past(reg_wdata_in, 3); endproperty
  a_readback: assert property (p_readback) else $error("function readback wrong");
  property p_off; code_r == 5'h0F |=> !indicator_lamp_pin_out; endproperty
  a_off: assert property (p_off) else $error("forced off lamp lit");
  property p_on; code_r == 5'h0E && !off_r |=> indicator_lamp_pin_out; endproperty
  a_on: assert property (p_on) else $error("forced on lamp dark");
  property p_link; code_r == 5'h04 && !off_r |=> indicator_lamp_pin_out == $past(link_up_in);
  endproperty
  a_link: assert property (p_link) else $error("link lamp wrong");
  property p_reserved; code_r inside {5'h00, 5'h01, 5'h02, 5'h11, 5'h14, 5'h15, 5'h16, 5'h18}
    |=> !indicator_lamp_pin_out; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code lit");
  property p_oe; off_r |=> !indicator_lamp_pin_oe_out && !indicator_lamp_pin_out; endproperty
  a_oe: assert property (p_oe) else $error("disabled lamp still driven");
  c_disabled: cover property (off_r);
  c_blink: cover property (code_r == 5'h0D && indicator_lamp_pin_out);
  c_reserved: cover property (code_r == 5'h18);
endmodule // lamp_driver_monitor

bind lamp_driver lamp_driver_monitor mon_u (.mclk_in, .rst_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .link_up_in, .speed_100_in,
  .full_duplex_in, .tx_active_in, .rx_active_in, .collision_in, .indicator_lamp_pin_out,
  .indicator_lamp_pin_oe_out);

// File: dv/lamp_model.sv
/*
  External indicator lamp seen from the pin.
  Assumes lamp level high means lit and a pull-down on the undriven pin.
*/
`timescale 1ns/1ps
module lamp_model (
  input  wire logic lamp_in,
  input  wire logic lamp_oe_in,
  output logic      lit_out
);
  // Released pin falls to the pull-down, so the lamp goes dark
  assign lit_out = lamp_oe_in & lamp_in;
endmodule // lamp_model

// File: dv/lamp_driver_tb.sv
/*
  Self-checking bench for the lamp driver: function table, register access,
  output disable, pulse stretching, reset values and pattern stepping.
  Assumes the checker is bound in and a 1 ms timebase of 100000 cycles.
*/
`timescale 1ns/1ps
module lamp_driver_tb;
  logic        mclk_in, rst_in, reg_wr_in, reg_rd_in, reg_ack_out;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic        link_up_in, speed_100_in, full_duplex_in;
  logic        tx_active_in, rx_active_in, collision_in;
  logic        indicator_lamp_pin_out, indicator_lamp_pin_oe_out, lit;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Row: code, inputs {link,100M,fdx,tx,rx,col}, {pattern bit 0, lamp}
  localparam logic [12:0] ROWS [42] = '{
    {5'h1F,6'h20,2'h1}, {5'h1F,6'h30,2'h0}, {5'h1D,6'h30,2'h1}, {5'h1D,6'h20,2'h0},
    {5'h1C,6'h30,2'h1}, {5'h1C,6'h20,2'h2}, {5'h1B,6'h20,2'h3}, {5'h1B,6'h30,2'h2},
    {5'h1A,6'h04,2'h3}, {5'h1A,6'h02,2'h2}, {5'h19,6'h02,2'h3}, {5'h19,6'h00,2'h2},
    {5'h13,6'h34,2'h0}, {5'h13,6'h30,2'h1}, {5'h12,6'h20,2'h1}, {5'h12,6'h30,2'h0},
    {5'h10,6'h20,2'h1}, {5'h10,6'h00,2'h2}, {5'h0F,6'h3F,2'h2}, {5'h0E,6'h00,2'h1},
    {5'h0D,6'h00,2'h3}, {5'h0D,6'h00,2'h0}, {5'h0C,6'h28,2'h1}, {5'h0C,6'h29,2'h0},
    {5'h0B,6'h20,2'h1}, {5'h0B,6'h22,2'h0}, {5'h0A,6'h24,2'h0}, {5'h09,6'h01,2'h1},
    {5'h09,6'h00,2'h2}, {5'h08,6'h28,2'h1}, {5'h08,6'h20,2'h2}, {5'h07,6'h02,2'h1},
    {5'h06,6'h04,2'h0}, {5'h06,6'h02,2'h1}, {5'h05,6'h04,2'h1}, {5'h05,6'h02,2'h0},
    {5'h04,6'h20,2'h1}, {5'h04,6'h00,2'h2}, {5'h03,6'h30,2'h3}, {5'h03,6'h20,2'h2},
    {5'h18,6'h3F,2'h2}, {5'h00,6'h3F,2'h2}};

  lamp_driver dut_u (.mclk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_ack_out, .link_up_in, .speed_100_in, .full_duplex_in,
    .tx_active_in, .rx_active_in, .collision_in, .indicator_lamp_pin_out,
    .indicator_lamp_pin_oe_out);
  lamp_model lamp_u (.lamp_in(indicator_lamp_pin_out), .lamp_oe_in(indicator_lamp_pin_oe_out),
    .lit_out(lit));

  // ------------------
  // Checking and access
  // ------------------
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One-cycle strobe; ack and read data are looked at mid-cycle after it
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= w;
    reg_rd_in    <= !w;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk_bit(reg_ack_out, 1'b1, "ack");
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk_word(reg_rdata_out, e, "read data");
  endtask
  task automatic setin(input logic [5:0] v);
    @(posedge mclk_in);
    {link_up_in, speed_100_in, full_duplex_in, tx_active_in, rx_active_in, collision_in} <= v;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic do_reset;
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Run needs about 102000 cycles, mostly the 1 ms pattern step
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 120000) begin
      n_fail++;
      $display("mismatch at %0t: run did not finish", $time);
      test_done();
    end
  end

  initial begin
    logic [12:0] r;
    rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {link_up_in, speed_100_in, full_duplex_in, tx_active_in, rx_active_in, collision_in} = '0;
    do_reset();
    // Stretching off so event inputs show at once
    foreach (ROWS[i]) begin
      r = ROWS[i];
      acc(1'b1, lamp_pkg::ADDR_CONTROL_FIRST, {5'h00, r[12], 10'h000});
      acc(1'b1, lamp_pkg::ADDR_FUNCTION_LOW, {12'h210, r[11:8]});
      acc(1'b1, lamp_pkg::ADDR_BLINK_PATTERN, {15'h0C2A, r[1]});
      setin(r[7:2]);
      settle(4);
      chk_bit(lit, r[0], "lamp");
    end
    acc(1'b1, lamp_pkg::ADDR_BLINK_PATTERN, 16'hFFFF);
    rd_chk(lamp_pkg::ADDR_BLINK_PATTERN, 16'h3FFF);
    acc(1'b1, lamp_pkg::ADDR_FUNCTION_LOW, 16'h2103);
    rd_chk(lamp_pkg::ADDR_FUNCTION_LOW, 16'h2103);
    acc(1'b1, 16'h001E, 16'hFFFF);
    rd_chk(16'h001E, 16'h0000);
    acc(1'b1, lamp_pkg::ADDR_FUNCTION_LOW, 16'h210E);
    acc(1'b1, lamp_pkg::ADDR_CONTROL_FIRST, 16'h0002);
    settle(3);
    chk_bit(indicator_lamp_pin_oe_out, 1'b0, "disabled enable");
    chk_bit(indicator_lamp_pin_out, 1'b0, "disabled level");
    acc(1'b1, lamp_pkg::ADDR_CONTROL_FIRST, 16'h0000);
    settle(3);
    chk_bit(lit, 1'b1, "enabled lamp");
    setin(6'h00);
    acc(1'b1, lamp_pkg::ADDR_CONTROL_FIRST, 16'h0001);
    acc(1'b1, lamp_pkg::ADDR_FUNCTION_LOW, 16'h2105);
    setin(6'h04);
    setin(6'h00);
    settle(50);
    chk_bit(lit, 1'b1, "stretched transmit");
    acc(1'b1, lamp_pkg::ADDR_CONTROL_FIRST, 16'h0000);
    settle(4);
    chk_bit(lit, 1'b0, "unstretched transmit");
    // Second reset in mid-run, then the 1 ms pattern step from bit 0 to bit 1
    setin(6'h20);
    do_reset();
    rd_chk(lamp_pkg::ADDR_CONTROL_FIRST, 16'h0001);
    rd_chk(lamp_pkg::ADDR_FUNCTION_LOW, 16'h210A);
    rd_chk(lamp_pkg::ADDR_BLINK_PATTERN, 16'h1855);
    settle(3);
    chk_bit(lit, 1'b1, "default lamp with link");
    acc(1'b1, lamp_pkg::ADDR_FUNCTION_LOW, 16'h210D);
    acc(1'b1, lamp_pkg::ADDR_BLINK_PATTERN, 16'h3F02);
    settle(4);
    chk_bit(lit, 1'b0, "pattern bit 0");
    settle(97000);
    chk_bit(lit, 1'b0, "pattern bit 0 held");
    settle(4000);
    chk_bit(lit, 1'b1, "pattern bit 1");
    test_done();
  end
endmodule // lamp_driver_tb
